/* src/bgpio_pkg.sv */
/*
 * Constants shared by the banked GPIO block: pin and bank counts, the
 * register map, reset values and AXI4-Lite response codes.
 * Assumes a single 200 MHz peripheral clock and 32-bit AXI4-Lite data.
 */
`default_nettype none

package bgpio_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Pin organisation
   localparam int NUM_PINS = 104;
   localparam int BANK_PINS = 16;
   localparam int NUM_BANKS = 7;
   localparam int NUM_DED = 10;
   localparam int ADDR_W = 8;

   // Clock rate and shortest pin pulse the synchroniser must see
   localparam int CLK_PERIOD_NS = 5;
   localparam int PULSE_MIN_NS = 52;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Register map: each register spans four words, bit n is pin n
   typedef enum logic [3:0] {
      BGPIO_DIR = 4'b0000,
      BGPIO_OUT = 4'b0001,
      BGPIO_SET = 4'b0010,
      BGPIO_CLR = 4'b0011,
      BGPIO_IN = 4'b0100,
      BGPIO_RISE = 4'b0101,
      BGPIO_FALL = 4'b0110,
      BGPIO_STAT = 4'b0111,
      BGPIO_MASK = 4'b1000
   } bgpio_reg_t;

   // Byte offsets of each register's first word
   localparam logic [7:0] OFS_DIR = 8'h00;
   localparam logic [7:0] OFS_OUT = 8'h10;
   localparam logic [7:0] OFS_SET = 8'h20;
   localparam logic [7:0] OFS_CLR = 8'h30;
   localparam logic [7:0] OFS_IN = 8'h40;
   localparam logic [7:0] OFS_RISE = 8'h50;
   localparam logic [7:0] OFS_FALL = 8'h60;
   localparam logic [7:0] OFS_STAT = 8'h70;
   localparam logic [7:0] OFS_MASK = 8'h80;
   localparam logic [7:0] OFS_LAST = 8'h8C;

   // Field positions inside a byte address
   localparam int SEL_LSB = 4;
   localparam int WORD_LSB = 2;

   // Reset values: all pins inputs, outputs low, no edges armed
   localparam logic [NUM_PINS-1:0] DIR_RST = {NUM_PINS{1'b1}};
   localparam logic [NUM_PINS-1:0] OUT_RST = {NUM_PINS{1'b0}};
   localparam logic [NUM_PINS-1:0] EDGE_RST = {NUM_PINS{1'b0}};
   localparam logic [NUM_PINS-1:0] STAT_RST = {NUM_PINS{1'b0}};
   localparam logic [NUM_PINS-1:0] MASK_RST = {NUM_PINS{1'b0}};

   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage : bgpio_pkg

`default_nettype wire

/* src/bgpio_pin_sync.sv */
/*
 * Three-stage pin synchroniser with edge detection for a vector of pins.
 * A new level is accepted once the second and third stages agree; rise
 * and fall come out as one-cycle pulses from flip-flops.
 * Assumes pins are asynchronous to sys_clk and held at least two cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module bgpio_pin_sync #(
   parameter int W = 104
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] rise_r;
   logic [W-1:0] fall_r;
   logic [2:0] prime_r;
   logic done_r;
   logic [W-1:0] agree;

   ////////////////////////////////////////////////////////////////////////
   // Stage one is read only by stage two
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign agree = ~(s2_r ^ s3_r);

   // Priming: the first settled level is loaded without an edge
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prime_r <= 3'h0;
         done_r <= 1'b0;
      end
      else
      begin
         prime_r <= {prime_r[1:0], 1'b1};
         done_r <= done_r | prime_r[2];
      end
   end

   // Level and edge pulses; an edge needs two agreeing stages
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_r <= '0;
         rise_r <= '0;
         fall_r <= '0;
      end
      else
      begin
         lvl_r <= (lvl_r & ~agree) | (s3_r & agree); // [RULE_15]
         rise_r <= {W{done_r}} & agree & s3_r & ~lvl_r; // [RULE_15]
         fall_r <= {W{done_r}} & agree & ~s3_r & lvl_r; // [RULE_15]
      end
   end

   assign level = lvl_r;
   assign rise = rise_r;
   assign fall = fall_r;

endmodule : bgpio_pin_sync

`default_nettype wire

/* src/bgpio_top.sv */
/*
 * Banked GPIO with edge events: 104 pins, AXI4-Lite register slave,
 * per-pin direction, output, set/clear, input, edge select, sticky
 * status with mask, and interrupt and DMA event outputs.
 * Assumes one master with at most one write and one read under way,
 * and a pad ring that resolves each pin from gpio_out and gpio_oe.
 */
`timescale 1ns/100ps
`default_nettype none

// Function
// [RULE_01] Each pin is individually input or output
// [RULE_02] Output pin drives its output register bit
// [RULE_03] Input pin level readable in input register
// [RULE_04] Banks of sixteen pins, bank zero pins 0-15
// [RULE_05] 104 pins over seven banks, last partial
// [RULE_06] Dedicated interrupt for pins nine down to zero
// [RULE_07] One aggregated interrupt per bank, seven total
// [RULE_08] Rising, falling or both edges selectable
// [RULE_09] Dedicated DMA event for pins nine to zero
// [RULE_10] One aggregated DMA event per bank
// [RULE_11] Write one sets or clears, zero leaves bit
// [RULE_12] Input and output state in separate registers
// [RULE_13] Full word write into output register
// [RULE_14] Output register reads back commanded drive
// [RULE_15] Synchronise inputs; edges become one-cycle pulses
module bgpio_top #(
   parameter int NUM_PINS = bgpio_pkg::NUM_PINS,
   parameter int BANK_PINS = bgpio_pkg::BANK_PINS,
   parameter int NUM_BANKS = bgpio_pkg::NUM_BANKS,
   parameter int NUM_DED = bgpio_pkg::NUM_DED
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [bgpio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [bgpio_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic [NUM_PINS-1:0] gpio_in,
   output logic [NUM_PINS-1:0] gpio_out,
   output logic [NUM_PINS-1:0] gpio_oe,
   // Events
   output logic irq,
   output logic [NUM_DED-1:0] irq_pin,
   output logic [NUM_BANKS-1:0] irq_bank,
   output logic [NUM_DED-1:0] dma_pin,
   output logic [NUM_BANKS-1:0] dma_bank
);

   localparam int PAD_W = 128;

   // Register state
   logic [NUM_PINS-1:0] dir_r;
   logic [NUM_PINS-1:0] out_r;
   logic [NUM_PINS-1:0] rise_en_r;
   logic [NUM_PINS-1:0] fall_en_r;
   logic [NUM_PINS-1:0] stat_r;
   logic [NUM_PINS-1:0] mask_r;
   logic [NUM_PINS-1:0] stat_nxt;
   logic [NUM_PINS-1:0] pend;

   // Synchroniser outputs and qualified events
   logic [NUM_PINS-1:0] pin_lvl;
   logic [NUM_PINS-1:0] pin_rise;
   logic [NUM_PINS-1:0] pin_fall;
   logic [NUM_PINS-1:0] ev;

   // Write channel holding registers, write and read responses
   logic aw_held_r;
   logic w_held_r;
   logic [bgpio_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   // Write decode
   logic wr_do;
   logic wr_ok;
   logic [3:0] wr_sel;
   logic [1:0] wr_word;
   logic [31:0] lane_m;
   logic [PAD_W-1:0] m_pad;
   logic [NUM_PINS-1:0] wr_m;
   logic [NUM_PINS-1:0] wr_d;
   logic [PAD_W-1:0] d_pad;
   logic [NUM_PINS-1:0] wr_bits;

   // Read decode
   logic rd_do;
   logic rd_ok;
   logic [3:0] rd_sel;
   logic [1:0] rd_word;
   logic [31:0] rd_val;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge detector
   bgpio_pin_sync #(
      .W(NUM_PINS)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin_in(gpio_in),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Edge selection per pin; both enables give both edges
   assign ev = (pin_rise & rise_en_r) | (pin_fall & fall_en_r); // [RULE_08]

   ////////////////////////////////////////////////////////////////////////
   // Selects a 32-bit word of a pin vector; bits past the last pin read 0
   function automatic logic [31:0] pick_word(input logic [NUM_PINS-1:0] v,
                                             input logic [1:0] w);
      logic [PAD_W-1:0] p;
      p = {{(PAD_W-NUM_PINS){1'b0}}, v};
      pick_word = p[32*w +: 32];
   endfunction : pick_word

   ////////////////////////////////////////////////////////////////////////
   // AXI write channels: address and data may arrive in either order
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign wr_do = aw_held_r && w_held_r && !bvalid_r;
   assign wr_sel = awaddr_r[bgpio_pkg::SEL_LSB +: 4];
   assign wr_word = awaddr_r[bgpio_pkg::WORD_LSB +: 2];
   assign wr_ok = awaddr_r <= bgpio_pkg::OFS_LAST;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (wr_do)
         begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (wr_do)
         begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer DECERR
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= bgpio_pkg::RESP_OKAY;
      end
      else if (wr_do)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_ok ? bgpio_pkg::RESP_OKAY : bgpio_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Byte strobes become a pin mask at the addressed word
   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         lane_m[8*k +: 8] = {8{wstrb_r[k]}};
      end
   end

   assign m_pad = {{(PAD_W-32){1'b0}}, lane_m} << (32 * wr_word);
   assign wr_m = m_pad[NUM_PINS-1:0];
   // Data word copied to every lane; the mask picks the addressed one
   assign d_pad = {4{wdata_r}};
   assign wr_d = d_pad[NUM_PINS-1:0];
   assign wr_bits = wr_m & wr_d;

   ////////////////////////////////////////////////////////////////////////
   // Direction: 1 is input, 0 drives the pin
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dir_r <= bgpio_pkg::DIR_RST;
      end
      else if (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_DIR)
      begin
         dir_r <= (dir_r & ~wr_m) | wr_bits; // [RULE_01]
      end
   end

   // Output register: direct word write, or set and clear by ones;
   // one writer at a time, so lock-free toggling needs no arbitration
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_r <= bgpio_pkg::OUT_RST;
      end
      else if (wr_do && wr_ok)
      begin
         case (wr_sel)
            bgpio_pkg::BGPIO_OUT: out_r <= (out_r & ~wr_m) | wr_bits; // [RULE_13]
            bgpio_pkg::BGPIO_SET: out_r <= out_r | wr_bits; // [RULE_11]
            bgpio_pkg::BGPIO_CLR: out_r <= out_r & ~wr_bits; // [RULE_11]
            default: out_r <= out_r;
         endcase
      end
   end

   // Pads: drive only the pins set as outputs
   assign gpio_out = out_r; // [RULE_02]
   assign gpio_oe = ~dir_r; // [RULE_01]

   // Edge enables
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rise_en_r <= bgpio_pkg::EDGE_RST;
         fall_en_r <= bgpio_pkg::EDGE_RST;
      end
      else if (wr_do && wr_ok)
      begin
         if (wr_sel == bgpio_pkg::BGPIO_RISE)
         begin
            rise_en_r <= (rise_en_r & ~wr_m) | wr_bits; // [RULE_08]
         end
         if (wr_sel == bgpio_pkg::BGPIO_FALL)
         begin
            fall_en_r <= (fall_en_r & ~wr_m) | wr_bits; // [RULE_08]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky status, cleared by writing one; a new edge beats the clear
   always_comb
   begin
      stat_nxt = stat_r;
      if (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_STAT)
      begin
         stat_nxt = stat_r & ~wr_bits;
      end
      stat_nxt = stat_nxt | ev;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stat_r <= bgpio_pkg::STAT_RST;
         mask_r <= bgpio_pkg::MASK_RST;
      end
      else
      begin
         stat_r <= stat_nxt;
         if (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_MASK)
         begin
            mask_r <= (mask_r & ~wr_m) | wr_bits;
         end
      end
   end

   // Enabled pending events
   assign pend = stat_r & mask_r;
   assign irq = |pend;
   assign irq_pin = pend[NUM_DED-1:0]; // [RULE_06]

   // Dedicated DMA events, registered one-cycle pulses
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dma_pin <= '0;
      end
      else
      begin
         dma_pin <= ev[NUM_DED-1:0]; // [RULE_09]
      end
   end

   // Per-bank aggregation; the last bank holds only the remaining pins
   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      localparam int LO = b * BANK_PINS; // [RULE_04]
      localparam int HI = (LO + BANK_PINS > NUM_PINS) ? NUM_PINS - 1 : LO + BANK_PINS - 1; // [RULE_05]
      assign irq_bank[b] = |pend[HI:LO]; // [RULE_07]
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            dma_bank[b] <= 1'b0;
         end
         else
         begin
            dma_bank[b] <= |ev[HI:LO]; // [RULE_10]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI read channel, answered one cycle after the address is taken
   assign s_axi_arready = !rvalid_r;
   assign rd_do = s_axi_arvalid && s_axi_arready;
   assign rd_sel = s_axi_araddr[bgpio_pkg::SEL_LSB +: 4];
   assign rd_word = s_axi_araddr[bgpio_pkg::WORD_LSB +: 2];
   assign rd_ok = s_axi_araddr <= bgpio_pkg::OFS_LAST;

   // Input and output reads come from distinct state
   always_comb
   begin
      case (rd_sel)
         bgpio_pkg::BGPIO_DIR: rd_val = pick_word(dir_r, rd_word);
         bgpio_pkg::BGPIO_OUT: rd_val = pick_word(out_r, rd_word); // [RULE_14]
         bgpio_pkg::BGPIO_IN: rd_val = pick_word(pin_lvl, rd_word); // [RULE_03] [RULE_12]
         bgpio_pkg::BGPIO_RISE: rd_val = pick_word(rise_en_r, rd_word);
         bgpio_pkg::BGPIO_FALL: rd_val = pick_word(fall_en_r, rd_word);
         bgpio_pkg::BGPIO_STAT: rd_val = pick_word(stat_r, rd_word);
         bgpio_pkg::BGPIO_MASK: rd_val = pick_word(mask_r, rd_word);
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= bgpio_pkg::RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end
      else if (rd_do)
      begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_ok ? bgpio_pkg::RESP_OKAY : bgpio_pkg::RESP_DECERR;
         rdata_r <= rd_ok ? rd_val : 32'h0000_0000;
      end
      else if (s_axi_rready)
      begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_oe_follows_dir;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_DIR) |=>
         ((gpio_oe & $past(wr_m)) == (~$past(wr_d) & $past(wr_m)));
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir) // [RULE_01]
      else $error("oe does not follow direction write");

   property p_set_bits;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_SET) |=>
         ((gpio_out & $past(wr_bits)) == $past(wr_bits)) &&
         ((gpio_out & ~$past(wr_bits)) == ($past(gpio_out) & ~$past(wr_bits)));
   endproperty
   a_set_bits: assert property (p_set_bits) // [RULE_11]
      else $error("set write wrong");

   property p_clr_bits;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_CLR) |=>
         ((gpio_out & $past(wr_bits)) == '0) &&
         ((gpio_out & ~$past(wr_bits)) == ($past(gpio_out) & ~$past(wr_bits)));
   endproperty
   a_clr_bits: assert property (p_clr_bits) // [RULE_11]
      else $error("clear write wrong");

   property p_direct_out;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_do && wr_ok && wr_sel == bgpio_pkg::BGPIO_OUT) |=>
         ((gpio_out & $past(wr_m)) == $past(wr_bits));
   endproperty
   a_direct_out: assert property (p_direct_out) // [RULE_13]
      else $error("direct output write wrong");

   property p_read_out;
      @(posedge sys_clk) disable iff (!rst_b)
      (rd_do && rd_ok && rd_sel == bgpio_pkg::BGPIO_OUT) |=>
         s_axi_rvalid && (s_axi_rdata == pick_word($past(gpio_out), $past(rd_word)));
   endproperty
   a_read_out: assert property (p_read_out) // [RULE_14]
      else $error("output readback wrong");

   property p_read_in;
      @(posedge sys_clk) disable iff (!rst_b)
      (rd_do && rd_ok && rd_sel == bgpio_pkg::BGPIO_IN) |=>
         s_axi_rvalid && (s_axi_rdata == pick_word($past(pin_lvl), $past(rd_word)));
   endproperty
   a_read_in: assert property (p_read_in) // [RULE_03]
      else $error("input read wrong");

   property p_edge_select;
      @(posedge sys_clk) disable iff (!rst_b)
      (ev != '0) |-> ((ev & ~((pin_lvl & rise_en_r) | (~pin_lvl & fall_en_r))) == '0);
   endproperty
   a_edge_select: assert property (p_edge_select) // [RULE_08]
      else $error("event on disabled edge");

   property p_event_single;
      @(posedge sys_clk) disable iff (!rst_b)
      (ev & $past(ev)) == '0;
   endproperty
   a_event_single: assert property (p_event_single) // [RULE_15]
      else $error("event longer than one cycle");

   property p_dma_pulse;
      @(posedge sys_clk) disable iff (!rst_b)
      ev[3] |=> dma_pin[3] && dma_bank[0] ##1 !dma_pin[3];
   endproperty
   a_dma_pulse: assert property (p_dma_pulse) // [RULE_09]
      else $error("dma event pulse wrong");

   property p_irq_raise;
      @(posedge sys_clk) disable iff (!rst_b)
      (ev[100] && mask_r[100] && !(wr_do && wr_sel == bgpio_pkg::BGPIO_MASK)) |=>
         irq_bank[NUM_BANKS-1] && irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) // [RULE_07]
      else $error("bank interrupt missing");

   property p_irq_pin;
      @(posedge sys_clk) disable iff (!rst_b)
      (ev[3] && mask_r[3] && !(wr_do && wr_sel == bgpio_pkg::BGPIO_MASK)) |=> irq_pin[3];
   endproperty
   a_irq_pin: assert property (p_irq_pin) // [RULE_06]
      else $error("pin interrupt missing");

endmodule : bgpio_top

`default_nettype wire

/* dv/bgpio_pin_model.sv */
/*
 * External devices on the GPIO pins: a driven pin reads back its own
 * drive, an undriven pin follows the level that the bench sets.
 * Assumes the bench holds ext_lvl steady for at least two clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module bgpio_pin_model (
   input wire logic [bgpio_pkg::NUM_PINS-1:0] gpio_out,
   input wire logic [bgpio_pkg::NUM_PINS-1:0] gpio_oe,
   input wire logic [bgpio_pkg::NUM_PINS-1:0] ext_lvl,
   output logic [bgpio_pkg::NUM_PINS-1:0] pin_lvl
);
   // Pad resolution; a released pin never keeps the old drive level
   assign pin_lvl = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
endmodule : bgpio_pin_model

`default_nettype wire

/* dv/bgpio_tb_top.sv */
/*
 * Self-checking bench for the banked GPIO: AXI4-Lite master tasks and
 * one task per scenario. Assumes the pin model closes the pad loop.
 */
`timescale 1ns/100ps
`default_nettype none

module bgpio_tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = '0;
   logic [7:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [103:0] ext_lvl = 104'h200;
   wire logic [103:0] gpio_in;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [103:0] gpio_out, gpio_oe;
   logic [9:0] irq_pin, dma_pin;
   logic [6:0] irq_bank, dma_bank;
   int n_mismatch = 0;
   int compares = 0;

   // Clock of 5 ns
   always #2.5 sys_clk = ~sys_clk;

   bgpio_top bgpio_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq), .irq_pin(irq_pin),
      .irq_bank(irq_bank), .dma_pin(dma_pin), .dma_bank(dma_bank));

   bgpio_pin_model bgpio_pin_model_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .ext_lvl(ext_lvl), .pin_lvl(gpio_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge sys_clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask : rd

   // Moves one pin and counts bank and dedicated event pulses
   task automatic cnt(input int p, input logic v, output logic [31:0] nb,
                      output logic [31:0] np);
      nb = '0;
      np = '0;
      ext_lvl[p] <= v;
      repeat (12)
      begin
         @(posedge sys_clk);
         nb += dma_bank[p / 16];
         if (p < 10) np += dma_pin[p];
      end
   endtask : cnt

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h00, d, r);
      chk(d, 32'hffff_ffff);
      chk(gpio_oe[31:0], 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_out;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h00, 32'hffff_ff00, r);
      wr(8'h10, 32'h0000_00a5, r);
      chk(gpio_oe[31:0], 32'h0000_00ff);
      chk(gpio_out[31:0], 32'h0000_00a5);
      wr(8'h20, 32'h0000_0102, r);
      wr(8'h30, 32'h0000_0021, r);
      chk(gpio_out[31:0], 32'h0000_0186);
      rd(8'h10, d, r);
      chk(d, 32'h0000_0186);
      repeat (4) @(posedge sys_clk);
      rd(8'h40, d, r);
      chk(d, 32'h0000_0286);
      // One byte lane only; pin 3 stays low so no edge reaches t_edge
      wstrb <= 4'h1;
      wr(8'h10, 32'h0000_ff71, r);
      wstrb <= 4'hf;
      chk(gpio_out[31:0], 32'h0000_0171);
      $display("test output done");
   endtask : t_out

   task automatic t_edge;
      logic [31:0] d, nb, np;
      logic [1:0] r;
      wr(8'h00, 32'hffff_ffff, r);
      wr(8'h50, 32'h0000_0008, r);
      wr(8'h60, 32'h0000_0008, r);
      wr(8'h80, 32'h0000_0008, r);
      cnt(3, 1'b1, nb, np);
      chk(nb, 32'h0000_0001);
      chk(np, 32'h0000_0001);
      chk({irq, irq_bank[0], irq_pin[3]}, 32'h0000_0007);
      rd(8'h70, d, r);
      chk(d, 32'h0000_0008);
      wr(8'h70, 32'h0000_0008, r);
      chk(irq, 1'b0);
      cnt(3, 1'b0, nb, np);
      chk(nb, 32'h0000_0001);
      wr(8'h80, 32'h0000_0000, r);
      chk({irq, irq_bank[0], irq_pin[3]}, 32'h0000_0000);
      wr(8'h70, 32'h0000_0008, r);
      // Last, partly filled bank: pin 100 armed for rising edges only
      wr(8'h5c, 32'h0000_0010, r);
      wr(8'h8c, 32'h0000_0010, r);
      cnt(100, 1'b1, nb, np);
      chk(nb, 32'h0000_0001);
      chk({irq, irq_bank}, 32'h0000_00c0);
      cnt(100, 1'b0, nb, np);
      chk(nb, 32'h0000_0000);
      $display("test edge done");
   endtask : t_edge

   task automatic t_err;
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h90, d, r);
      chk(r, 32'h0000_0003);
      chk(d, 32'h0000_0000);
      wr(8'h90, 32'h0000_ffff, r);
      chk(r, 32'h0000_0003);
      $display("test unmapped done");
   endtask : t_err

   task automatic results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////
   // Main sequence after a reset of four clocks
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge sys_clk);
      t_reset;
      t_out;
      t_edge;
      t_err;
      results;
   end

   // Watchdog far beyond the under two hundred cycles the tests need
   initial
   begin
      #50000;
      n_mismatch++;
      results;
   end
endmodule : bgpio_tb_top

`default_nettype wire
